// File: rtl/pia_defines.vh
/*
 * register map, field positions, reset values and port layout of the
 * per-port interrupt aggregator.
 * assumes: included by the aggregator only; apb byte address = 4 * index,
 * where index = port number in bits 13:12 and register offset below.
 */
`ifndef PIA_DEFINES_VH
`define PIA_DEFINES_VH

// ------------------------------------------------------------------
// register indices (byte address = index * 4)
// ------------------------------------------------------------------
`define PIA_IDX_STATUS      12'h01B
`define PIA_IDX_MASK        12'h01F
`define PIA_IDX_OPCTL0      12'h020
`define PIA_PORT_FIRST      2'h1
`define PIA_PORT_LAST       2'h3
`define PIA_ADDR_W          16

// ------------------------------------------------------------------
// register select codes
// ------------------------------------------------------------------
`define PIA_SEL_NONE        2'h0
`define PIA_SEL_STATUS      2'h1
`define PIA_SEL_MASK        2'h2
`define PIA_SEL_OPCTL0      2'h3

// ------------------------------------------------------------------
// fields
// ------------------------------------------------------------------
`define PIA_BIT_PTP         2
`define PIA_BIT_PHY         1
`define PIA_BIT_ACL         0
`define PIA_BIT_LOOP_LOCAL  7
`define PIA_OPCTL0_WMASK    8'hC7

// ------------------------------------------------------------------
// reset values and port layout
// ------------------------------------------------------------------
`define PIA_RST_STATUS      8'h00
`define PIA_RST_MASK        3'h0
`define PIA_RST_OPCTL0      8'h00
`define PIA_PHY_PORT_MAP    3'h3

`endif

// File: rtl/pia_port_irq.v
/*
 * per-port interrupt status/mask aggregator with local mac loopback
 * for a three-port switch, reached over an apb slave.
 * assumes: one 10 mhz clock; event and frame inputs come from logic on
 * the same clock; acl events are one-cycle pulses, ptp/phy are levels.
 */
// Functional notes
// - ports 1 to 3 each own a read-only status and a mask register alike.
// - status bit 2 shows a pending time-stamp irq on integrated-phy ports.
// - status bit 1 shows a pending phy irq on integrated-phy ports only.
// - status bit 0 is set by an acl counter-mode irq, on every port.
// - the acl status bit clears when software toggles mask bit 0.
// - mask bits are active low, 0 enables and 1 suppresses the source.
// - all three mask bits reset to 0.
// - mask bit 2 acts only on integrated-phy ports.
// - mask bit 0 works on every port, the mac port included.
// - control bit 7 turns egress frames around in the mac to the fabric.
// - the local loopback bit resets to 0, normal forwarding.
`timescale 1ns/100ps
`include "pia_defines.vh"

module pia_port_irq (
  CLK,
  RESETN,
  PSEL,
  PENABLE,
  PWRITE,
  PADDR,
  PWDATA,
  PRDATA,
  PREADY,
  PSLVERR,
  PTP_IRQ_IN,
  PHY_IRQ_IN,
  ACL_EVENT,
  FAB_TX_VALID,
  FAB_TX_DATA,
  MAC_RX_VALID,
  MAC_RX_DATA,
  MAC_TX_VALID,
  MAC_TX_DATA,
  FAB_RX_VALID,
  FAB_RX_DATA,
  LOOP_LOCAL,
  PORT_IRQ,
  IRQ
);
  input  wire                   CLK;
  input  wire                   RESETN;
  input  wire                   PSEL;
  input  wire                   PENABLE;
  input  wire                   PWRITE;
  input  wire [`PIA_ADDR_W-1:0] PADDR;
  input  wire [31:0]            PWDATA;
  output wire [31:0]            PRDATA;
  output wire                   PREADY;
  output wire                   PSLVERR;
  input  wire [2:0]             PTP_IRQ_IN;
  input  wire [2:0]             PHY_IRQ_IN;
  input  wire [2:0]             ACL_EVENT;
  input  wire [2:0]             FAB_TX_VALID;
  input  wire [23:0]            FAB_TX_DATA;
  input  wire [2:0]             MAC_RX_VALID;
  input  wire [23:0]            MAC_RX_DATA;
  output wire [2:0]             MAC_TX_VALID;
  output wire [23:0]            MAC_TX_DATA;
  output wire [2:0]             FAB_RX_VALID;
  output wire [23:0]            FAB_RX_DATA;
  output wire [2:0]             LOOP_LOCAL;
  output wire [2:0]             PORT_IRQ;
  output wire                   IRQ;

  // ------------------------------------------------------------------
  // address decode
  // ------------------------------------------------------------------
  // one-hot port select; unaligned or port 0 addresses hit nothing
  function [2:0] port_onehot;
    input [`PIA_ADDR_W-1:0] a;
    begin
      port_onehot = 3'h0;
      if (a[1:0] == 2'h0) begin
        case (a[15:14])
          2'h1:    port_onehot = 3'h1;
          2'h2:    port_onehot = 3'h2;
          2'h3:    port_onehot = 3'h4;
          default: port_onehot = 3'h0;
        endcase
      end
    end
  endfunction

  function [1:0] reg_select;
    input [`PIA_ADDR_W-1:0] a;
    begin
      case (a[13:2])
        `PIA_IDX_STATUS: reg_select = `PIA_SEL_STATUS;
        `PIA_IDX_MASK:   reg_select = `PIA_SEL_MASK;
        `PIA_IDX_OPCTL0: reg_select = `PIA_SEL_OPCTL0;
        default:         reg_select = `PIA_SEL_NONE;
      endcase
    end
  endfunction

  // status byte of one port; the mac port never shows ptp or phy
  function [7:0] status_byte;
    input ptp;
    input phy;
    input acl;
    input phy_port;
    begin
      status_byte = `PIA_RST_STATUS;
      status_byte[`PIA_BIT_PTP] = ptp & phy_port;
      status_byte[`PIA_BIT_PHY] = phy & phy_port;
      status_byte[`PIA_BIT_ACL] = acl;
    end
  endfunction

  // write strobe of one register of one port, in the access cycle
  function wr_strobe;
    input       fire;
    input       port_hit;
    input [1:0] s;
    input [1:0] want;
    begin
      wr_strobe = fire & port_hit & (s == want);
    end
  endfunction

  // ------------------------------------------------------------------
  // state
  // ------------------------------------------------------------------
  reg  [2:0]  mask_q [0:2];
  reg  [2:0]  mask_d [0:2];
  reg  [7:0]  opctl_q [0:2];
  reg  [7:0]  opctl_d [0:2];
  reg  [2:0]  acl_q;
  reg  [2:0]  acl_d;
  reg  [31:0] prdata_q;
  reg  [31:0] prdata_d;
  reg         pready_q;
  reg         pslverr_q;
  reg         pslverr_d;
  reg  [2:0]  port_irq_q;
  reg  [2:0]  port_irq_d;
  reg         irq_q;
  reg  [2:0]  loop_q;
  reg  [2:0]  mac_tx_valid_q;
  reg  [23:0] mac_tx_data_q;
  reg  [2:0]  fab_rx_valid_q;
  reg  [23:0] fab_rx_data_q;
  reg  [7:0]  stat [0:2];
  integer     i_stat;
  integer     i_wr;
  integer     i_irq;
  integer     i_rd;
  integer     i_rst;
  integer     i_reg;
  integer     i_lp;
  integer     i_in;

  wire [2:0]  hit      = port_onehot(PADDR);
  wire [1:0]  sel      = reg_select(PADDR);
  wire        setup    = PSEL & ~PENABLE;
  wire        wr_fire  = PSEL & PENABLE & PWRITE & pready_q;
  wire [2:0]  phy_port = `PIA_PHY_PORT_MAP;

  // ------------------------------------------------------------------
  // status view and register writes
  // ------------------------------------------------------------------
  always @* begin
    for (i_stat = 0; i_stat < 3; i_stat = i_stat + 1) begin
      stat[i_stat] = status_byte(PTP_IRQ_IN[i_stat], PHY_IRQ_IN[i_stat],
                                 acl_q[i_stat], phy_port[i_stat]);
    end
  end

  always @* begin
    for (i_wr = 0; i_wr < 3; i_wr = i_wr + 1) begin
      mask_d[i_wr]  = mask_q[i_wr];
      opctl_d[i_wr] = opctl_q[i_wr];
      acl_d[i_wr]   = acl_q[i_wr];
      if (wr_strobe(wr_fire, hit[i_wr], sel, `PIA_SEL_MASK)) begin
        mask_d[i_wr] = PWDATA[2:0];
        // the status bit is read-only; a toggle of its mask is the clear
        if (PWDATA[`PIA_BIT_ACL] != mask_q[i_wr][`PIA_BIT_ACL]) begin
          acl_d[i_wr] = 1'b0;
        end
      end
      if (wr_strobe(wr_fire, hit[i_wr], sel, `PIA_SEL_OPCTL0)) begin
        opctl_d[i_wr] = PWDATA[7:0] & `PIA_OPCTL0_WMASK;
      end
      // a new event in the clearing cycle is kept
      if (ACL_EVENT[i_wr]) begin
        acl_d[i_wr] = 1'b1;
      end
    end
  end

  // ------------------------------------------------------------------
  // interrupt request per port
  // ------------------------------------------------------------------
  always @* begin
    for (i_irq = 0; i_irq < 3; i_irq = i_irq + 1) begin
      // mac port masks ignore the ptp bit since its status reads 0
      port_irq_d[i_irq] = |(stat[i_irq][2:0] & ~mask_q[i_irq]);
    end
  end

  // ------------------------------------------------------------------
  // apb read path
  // ------------------------------------------------------------------
  always @* begin
    prdata_d  = 32'h0000_0000;
    pslverr_d = 1'b0;
    if (hit == 3'h0 || sel == `PIA_SEL_NONE) begin
      pslverr_d = 1'b1;
    end else begin
      for (i_rd = 0; i_rd < 3; i_rd = i_rd + 1) begin
        if (hit[i_rd]) begin
          case (sel)
            `PIA_SEL_STATUS: prdata_d[7:0] = stat[i_rd];
            `PIA_SEL_MASK:   prdata_d[2:0] = mask_q[i_rd];
            `PIA_SEL_OPCTL0: prdata_d[7:0] = opctl_q[i_rd];
            default:         prdata_d      = 32'h0000_0000;
          endcase
        end
      end
    end
  end

  // ------------------------------------------------------------------
  // registers
  // ------------------------------------------------------------------
  // per-port configuration; only the acl status bit is stored
  always @(posedge CLK) begin
    if (!RESETN) begin
      for (i_rst = 0; i_rst < 3; i_rst = i_rst + 1) begin
        mask_q[i_rst]  <= `PIA_RST_MASK;
        opctl_q[i_rst] <= `PIA_RST_OPCTL0;
      end
      acl_q <= 3'h0;
    end else begin
      for (i_reg = 0; i_reg < 3; i_reg = i_reg + 1) begin
        mask_q[i_reg]  <= mask_d[i_reg];
        opctl_q[i_reg] <= opctl_d[i_reg];
      end
      acl_q <= acl_d;
    end
  end

  // ------------------------------------------------------------------
  // apb answer
  // ------------------------------------------------------------------
  // one access cycle, no wait states; read data is taken at setup
  always @(posedge CLK) begin
    if (!RESETN) begin
      prdata_q  <= 32'h0000_0000;
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      pready_q <= setup;
      if (setup) begin
        prdata_q  <= PWRITE ? 32'h0000_0000 : prdata_d;
        pslverr_q <= pslverr_d;
      end else begin
        pslverr_q <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------------
  // interrupt outputs
  // ------------------------------------------------------------------
  // irq is built from the same next values so it never lags port_irq
  always @(posedge CLK) begin
    if (!RESETN) begin
      port_irq_q <= 3'h0;
      irq_q      <= 1'b0;
    end else begin
      port_irq_q <= port_irq_d;
      irq_q      <= |port_irq_d;
    end
  end

  // ------------------------------------------------------------------
  // local mac loopback datapath
  // ------------------------------------------------------------------
  // one register stage per direction; egress is held off the wire
  // while looped so no frame is sent twice
  always @(posedge CLK) begin
    if (!RESETN) begin
      loop_q         <= 3'h0;
      mac_tx_valid_q <= 3'h0;
      mac_tx_data_q  <= 24'h00_0000;
    end else begin
      for (i_lp = 0; i_lp < 3; i_lp = i_lp + 1) begin
        loop_q[i_lp] <= opctl_q[i_lp][`PIA_BIT_LOOP_LOCAL];
        if (opctl_q[i_lp][`PIA_BIT_LOOP_LOCAL]) begin
          mac_tx_valid_q[i_lp]       <= 1'b0;
          mac_tx_data_q[i_lp*8 +: 8] <= 8'h00;
        end else begin
          mac_tx_valid_q[i_lp]       <= FAB_TX_VALID[i_lp];
          mac_tx_data_q[i_lp*8 +: 8] <= FAB_TX_DATA[i_lp*8 +: 8];
        end
      end
    end
  end

  // ingress: the mac's own traffic is dropped while the port loops
  always @(posedge CLK) begin
    if (!RESETN) begin
      fab_rx_valid_q <= 3'h0;
      fab_rx_data_q  <= 24'h00_0000;
    end else begin
      for (i_in = 0; i_in < 3; i_in = i_in + 1) begin
        if (opctl_q[i_in][`PIA_BIT_LOOP_LOCAL]) begin
          fab_rx_valid_q[i_in]       <= FAB_TX_VALID[i_in];
          fab_rx_data_q[i_in*8 +: 8] <= FAB_TX_DATA[i_in*8 +: 8];
        end else begin
          fab_rx_valid_q[i_in]       <= MAC_RX_VALID[i_in];
          fab_rx_data_q[i_in*8 +: 8] <= MAC_RX_DATA[i_in*8 +: 8];
        end
      end
    end
  end

  // ------------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------------
  assign PRDATA       = prdata_q;
  assign PREADY       = pready_q;
  assign PSLVERR      = pslverr_q;
  assign PORT_IRQ     = port_irq_q;
  assign IRQ          = irq_q;
  assign LOOP_LOCAL   = loop_q;
  assign MAC_TX_VALID = mac_tx_valid_q;
  assign MAC_TX_DATA  = mac_tx_data_q;
  assign FAB_RX_VALID = fab_rx_valid_q;
  assign FAB_RX_DATA  = fab_rx_data_q;

endmodule // pia_port_irq

// File: sim/pia_port_irq_props.sv
/* checker of the per-port interrupt aggregator, ports only.
   assumes: bound to pia_port_irq; one clock, sync active-low reset. */
`timescale 1ns/100ps
module pia_port_irq_props (
  input wire        CLK,
  input wire        RESETN,
  input wire        PSEL,
  input wire        PENABLE,
  input wire        PWRITE,
  input wire [31:0] PRDATA,
  input wire        PREADY,
  input wire        PSLVERR,
  input wire [2:0]  ACL_EVENT,
  input wire [2:0]  FAB_TX_VALID,
  input wire [23:0] FAB_TX_DATA,
  input wire [2:0]  MAC_TX_VALID,
  input wire [2:0]  FAB_RX_VALID,
  input wire [23:0] FAB_RX_DATA,
  input wire [2:0]  LOOP_LOCAL,
  input wire [2:0]  PORT_IRQ,
  input wire        IRQ
);
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RESETN);
  a_ready_one_shot: assert property (
    PSEL && !PENABLE |=> PREADY ##1 !PREADY)
    else $error("pready not a single access cycle");
  a_err_with_ready: assert property (
    PSLVERR |-> PREADY && PRDATA == 32'h0)
    else $error("error without ready or with data");
  a_upper_read_zero: assert property (
    PREADY && !PWRITE |-> PRDATA[31:8] == 24'h0)
    else $error("upper read bits not zero");
  a_irq_is_or: assert property (
    IRQ == (|PORT_IRQ))
    else $error("irq differs from or of port requests");
  // mac port: ptp/phy never count, and unmasking acl also clears it
  a_mac_acl_only: assert property (
    $rose(PORT_IRQ[2]) |-> $past(ACL_EVENT[2], 2))
    else $error("mac port request without acl event");
  a_reset_values: assert property (
    !$past(RESETN) |-> LOOP_LOCAL == 3'h0 && PORT_IRQ == 3'h0)
    else $error("outputs not cleared by reset");
  a_loop_no_tx: assert property (
    LOOP_LOCAL[0] |-> !MAC_TX_VALID[0])
    else $error("egress sent to wire while looped");
  a_loop_valid: assert property (
    $past(RESETN) && LOOP_LOCAL[0] |->
      FAB_RX_VALID[0] == $past(FAB_TX_VALID[0]))
    else $error("looped valid not returned");
  a_loop_data: assert property (
    $past(RESETN) && LOOP_LOCAL[0] && FAB_RX_VALID[0] |->
      FAB_RX_DATA[7:0] == $past(FAB_TX_DATA[7:0]))
    else $error("looped data not returned");
  c_irq: cover property ($rose(IRQ));
  c_err: cover property (PSLVERR);
  c_loop: cover property (LOOP_LOCAL[0] && FAB_RX_VALID[0]);
endmodule // pia_port_irq_props

// File: sim/pia_port_irq_tb.sv
/* bench of pia_port_irq: register table, then interrupt, loopback, reset.
   assumes: rtl/ on the include path; every apb answer within 20 cycles. */
`timescale 1ns/100ps
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin n_mismatch++; \
  $display("MISMATCH t=%0t got=%0h exp=%0h", $time, g, e); end end
module pia_port_irq_tb;
  typedef struct packed {
    logic [15:0] a; logic w; logic [31:0] d; logic [31:0] e; logic er;
  } pia_row_t;
  logic        CLK, RESETN, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, IRQ;
  logic [15:0] PADDR;
  logic [31:0] PWDATA, PRDATA, rd;
  logic [2:0]  PTP_IRQ_IN, PHY_IRQ_IN, ACL_EVENT, FAB_TX_VALID, MAC_RX_VALID;
  logic [2:0]  MAC_TX_VALID, FAB_RX_VALID, LOOP_LOCAL, PORT_IRQ;
  logic [23:0] FAB_TX_DATA, MAC_RX_DATA, MAC_TX_DATA, FAB_RX_DATA;
  logic        er;
  int          n_mismatch = 0;
  int          n_checks = 0;
  // status is read-only; unmapped gives error; writes restore port 2
  pia_row_t rows [14] = '{
    '{16'h406C,0,0,0,0}, '{16'h407C,0,0,0,0}, '{16'h807C,0,0,0,0},
    '{16'hC07C,0,0,0,0}, '{16'h4080,0,0,0,0}, '{16'h807C,1,32'hFF,0,0},
    '{16'h807C,0,0,32'h07,0}, '{16'h8080,1,32'hFF,0,0},
    '{16'h8080,0,0,32'hC7,0}, '{16'h406C,1,32'hFF,0,0},
    '{16'h406C,0,0,0,0}, '{16'h0000,0,0,0,1}, '{16'h807C,1,0,0,0},
    '{16'h8080,1,0,0,0}};
  pia_port_irq dut (
    .CLK(CLK), .RESETN(RESETN), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
    .PREADY(PREADY), .PSLVERR(PSLVERR), .PTP_IRQ_IN(PTP_IRQ_IN),
    .PHY_IRQ_IN(PHY_IRQ_IN), .ACL_EVENT(ACL_EVENT),
    .FAB_TX_VALID(FAB_TX_VALID), .FAB_TX_DATA(FAB_TX_DATA),
    .MAC_RX_VALID(MAC_RX_VALID), .MAC_RX_DATA(MAC_RX_DATA),
    .MAC_TX_VALID(MAC_TX_VALID), .MAC_TX_DATA(MAC_TX_DATA),
    .FAB_RX_VALID(FAB_RX_VALID), .FAB_RX_DATA(FAB_RX_DATA),
    .LOOP_LOCAL(LOOP_LOCAL), .PORT_IRQ(PORT_IRQ), .IRQ(IRQ));
  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic give_verdict;
    $display("checks=%0d mismatches=%0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // pready is read right after the edge, so it is the sampled value
  task automatic apb(input logic [15:0] a, input logic w,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge CLK);
    PSEL <= 1'b1;
    PADDR <= a;
    PWRITE <= w;
    PWDATA <= d;
    @(posedge CLK);
    PENABLE <= 1'b1;
    do begin
      @(posedge CLK);
      n++;
    end while (PREADY !== 1'b1 && n < 20);
    rd = PRDATA;
    er = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
    if (PREADY !== 1'b1) begin
      n_mismatch++;
      give_verdict();
    end
  endtask
  task automatic rd_chk(input logic [15:0] a, input logic [31:0] e);
    apb(a, 1'b0, 32'h0);
    `CHK(rd, e)
  endtask
  // ----------------------------------------------------------------
  // sequence
  // ----------------------------------------------------------------
  initial begin
    CLK = 1'b0;
    forever #50 CLK = ~CLK;
  end
  initial begin
    {RESETN, PSEL, PENABLE, PWRITE, PADDR, PWDATA} = '0;
    {PTP_IRQ_IN, PHY_IRQ_IN, ACL_EVENT} = '0;
    {FAB_TX_VALID, MAC_RX_VALID} = 6'h3F;
    FAB_TX_DATA = 24'hC3B2A1;
    MAC_RX_DATA = 24'h665544;
    repeat (8) @(posedge CLK);
    RESETN <= 1'b1;
    foreach (rows[i]) begin
      apb(rows[i].a, rows[i].w, rows[i].d);
      `CHK(er, rows[i].er)
      if (!rows[i].w) `CHK(rd, rows[i].e)
    end
    @(posedge CLK) PTP_IRQ_IN <= 3'h7;
    repeat (3) @(negedge CLK);
    `CHK(PORT_IRQ, 3'h3)
    rd_chk(16'h406C, 32'h4);
    rd_chk(16'hC06C, 32'h0);
    apb(16'h407C, 1'b1, 32'h4);
    repeat (2) @(negedge CLK);
    `CHK(PORT_IRQ, 3'h2)
    @(posedge CLK) PTP_IRQ_IN <= 3'h0;
    PHY_IRQ_IN <= 3'h7;
    rd_chk(16'h806C, 32'h2);
    `CHK(PORT_IRQ, 3'h3)
    @(posedge CLK) PHY_IRQ_IN <= 3'h0;
    ACL_EVENT <= 3'h4;
    @(posedge CLK) ACL_EVENT <= 3'h0;
    repeat (3) @(negedge CLK);
    `CHK({IRQ, PORT_IRQ}, 4'hC)
    rd_chk(16'hC06C, 32'h1);
    apb(16'hC07C, 1'b1, 32'h1);
    rd_chk(16'hC06C, 32'h0);
    @(posedge CLK) ACL_EVENT <= 3'h4;
    @(posedge CLK) ACL_EVENT <= 3'h0;
    rd_chk(16'hC06C, 32'h1);
    `CHK(PORT_IRQ, 3'h0)
    apb(16'hC07C, 1'b1, 32'h0);
    rd_chk(16'hC06C, 32'h0);
    apb(16'h4080, 1'b1, 32'h80);
    repeat (3) @(negedge CLK);
    `CHK({LOOP_LOCAL, MAC_TX_VALID}, 6'h0E)
    `CHK(FAB_RX_DATA, 24'h6655A1)
    `CHK(MAC_TX_DATA[23:8], 16'hC3B2)
    // mid-run reset must drop the loop and the masks
    @(posedge CLK) RESETN <= 1'b0;
    repeat (2) @(posedge CLK);
    RESETN <= 1'b1;
    @(negedge CLK);
    `CHK(LOOP_LOCAL, 3'h0)
    rd_chk(16'h4080, 32'h0);
    rd_chk(16'h407C, 32'h0);
    give_verdict();
  end
endmodule // pia_port_irq_tb
bind pia_port_irq pia_port_irq_props u_props (
  .CLK(CLK), .RESETN(RESETN), .PSEL(PSEL), .PENABLE(PENABLE),
  .PWRITE(PWRITE), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
  .ACL_EVENT(ACL_EVENT), .FAB_TX_VALID(FAB_TX_VALID),
  .FAB_TX_DATA(FAB_TX_DATA), .MAC_TX_VALID(MAC_TX_VALID),
  .FAB_RX_VALID(FAB_RX_VALID), .FAB_RX_DATA(FAB_RX_DATA),
  .LOOP_LOCAL(LOOP_LOCAL), .PORT_IRQ(PORT_IRQ), .IRQ(IRQ));
